// *** abs_pkg.sv ***
/*
 * Shared constants, types and byte-layout helpers for the accelerometer
 * sample buffer read side.
 * Assumes one 125 MHz core clock; every user of it refers to names by scope.
 */
`default_nettype none

package abs_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [6:0] ADDR_X_A = 7'h04;
	localparam logic [6:0] ADDR_Y_A = 7'h06;
	localparam logic [6:0] ADDR_Y_B = 7'h07;
	localparam logic [6:0] ADDR_Z_A = 7'h08;
	localparam logic [6:0] ADDR_Z_B = 7'h09;
	localparam logic [6:0] ADDR_STATUS = 7'h0b;
	localparam logic [6:0] ADDR_BUF_FIRST = 7'h0c;
	localparam logic [6:0] ADDR_BUF_LAST_FAST = 7'h10;
	localparam logic [6:0] ADDR_BUF_LAST = 7'h11;
	localparam logic [6:0] ADDR_STEP = 7'h01;
	localparam logic [6:0] ADDR_STEP_FAST = 7'h02;

	// ************************************************************
	// Fields, sizes and reset values
	// ************************************************************
	localparam int SAMPLE_W = 12;
	localparam int TRIPLET_W = 36;
	localparam int PTR_W = 5;
	localparam int DEPTH = 32;
	localparam logic [5:0] CNT_FULL = 6'h20;
	localparam logic [5:0] CNT_RESET = 6'h00;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [7:0] STATUS_OFF = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [11:0] SAMPLE_RESET = 12'h000;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int STAT_WMRK_BIT = 7;
	localparam int STAT_OVF_BIT = 6;
	localparam int CMD_READ_BIT = 7;

	typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_DATA} abs_phase_t;

	// Lower address byte of one axis
	function automatic logic [7:0] abs_lo_byte(input logic [11:0] s, input logic be, input logic fast);
		abs_lo_byte = (be | fast) ? s[11:4] : s[7:0];
	endfunction

	// Upper address byte of one axis
	function automatic logic [7:0] abs_hi_byte(input logic [11:0] s, input logic be);
		abs_hi_byte = be ? {s[3:0], 4'h0} : {{4{s[11]}}, s[11:8]};
	endfunction

endpackage

`default_nettype wire

// *** abs_pin_sync.sv ***
/*
 * Two-stage synchroniser and edge finder for the three serial pins.
 * Assumes the pins are asynchronous to the core clock and change far
 * slower than it (link clock period several core cycles).
 */
`timescale 1ns/1ps
`default_nettype none

module abs_pin_sync (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [2:0] pin_i,
	output logic [2:0] lvl_o,
	output logic [2:0] rise_o,
	output logic [2:0] fall_o
);

	// ************************************************************
	// Synchroniser
	// ************************************************************
	logic [2:0] meta;
	logic [2:0] sync;
	logic [2:0] prev;

	// Idle levels: clock low, select high, data low
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta <= 3'h2;
			sync <= 3'h2;
			prev <= 3'h2;
		end else begin
			meta <= pin_i;
			sync <= meta;
			prev <= sync;
		end
	end

	// Edges come from the second and third stages only
	assign lvl_o = sync;
	assign rise_o = sync & ~prev;
	assign fall_o = ~sync & prev;

endmodule

`default_nettype wire

// *** abs_sample_buffer.sv ***
/*
 * Sample triplet buffer, FIFO order, 32 entries, with count, overflow
 * and watermark flags.
 * Assumes push, pop, flush and configuration come from the core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module abs_sample_buffer (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic mode_on_i,
	input wire logic flush_i,
	input wire logic [5:0] level_i,
	input wire logic push_i,
	input wire logic [35:0] data_i,
	input wire logic pop_i,
	output logic [35:0] head_o,
	output logic [5:0] count_o,
	output logic ovf_o,
	output logic wmrk_o
);

	logic [35:0] mem [abs_pkg::DEPTH];
	logic [4:0] wr_ptr;
	logic [4:0] rd_ptr;
	logic [5:0] next_count;
	logic [4:0] next_wr_ptr;
	logic [4:0] next_rd_ptr;
	logic next_ovf;
	wire full = (count_o == abs_pkg::CNT_FULL);
	wire clear = flush_i | ~mode_on_i;
	wire do_pop = pop_i & mode_on_i & (count_o != abs_pkg::CNT_RESET) & ~flush_i;
	// A pop in the same cycle frees a slot, so the arrival is kept
	wire accept = push_i & mode_on_i & (~full | do_pop | flush_i);
	wire ovf_evt = push_i & mode_on_i & full & ~do_pop & ~flush_i;
	wire [4:0] wr_slot = clear ? 5'h00 : wr_ptr;

	// ************************************************************
	// Next state
	// ************************************************************
	assign next_count = clear ? {5'h00, accept} : count_o + {5'h00, accept} - {5'h00, do_pop};
	assign next_wr_ptr = wr_slot + {4'h0, accept};
	assign next_rd_ptr = clear ? 5'h00 : rd_ptr + {4'h0, do_pop};
	// A clear or pop of the same cycle wins over an overflowing arrival
	assign next_ovf = ovf_evt | (ovf_o & ~clear & ~do_pop);
	assign head_o = mem[rd_ptr];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_o <= abs_pkg::CNT_RESET;
			wr_ptr <= 5'h00;
			rd_ptr <= 5'h00;
			ovf_o <= 1'b0;
			wmrk_o <= 1'b0;
		end else begin
			count_o <= next_count;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			ovf_o <= next_ovf;
			wmrk_o <= mode_on_i & (next_count >= level_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (accept) begin
			mem[wr_slot] <= data_i;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	cnt_never_above_a: assert property (count_o <= abs_pkg::CNT_FULL) else $error("count above full");
	ovf_on_full_a: assert property (push_i && mode_on_i && full && !pop_i && !flush_i |=> ovf_o && full)
		else $error("overflow not flagged");
	wmrk_track_a: assert property (mode_on_i && !flush_i && $stable(level_i) && count_o >= level_i && !pop_i |=> wmrk_o)
		else $error("watermark missed");
	wmrk_drop_a: assert property (wmrk_o |-> count_o >= $past(level_i)) else $error("watermark below level");
	flush_clear_a: assert property (flush_i && !push_i && level_i != 6'h00 |=> !wmrk_o && !ovf_o && count_o == 6'h00)
		else $error("flush did not clear");
	off_clear_a: assert property (!mode_on_i |=> !wmrk_o && !ovf_o && count_o == 6'h00)
		else $error("disable did not clear");
	pop_ovf_clear_a: assert property (do_pop && !push_i |=> !ovf_o && count_o == $past(count_o) - 6'h01)
		else $error("pop did not clear overflow");

endmodule

`default_nettype wire

// *** abs_top.sv ***
/*
 * Read side of the accelerometer output data and sample buffer: serial
 * register port, output data registers, buffer status and burst drain.
 * A sample leaves the buffer only once its last byte has been shifted out.
 * Assumes sample and configuration inputs are on the core clock and the
 * serial pins are asynchronous, mode 0, with the link clock far slower.
 */
// Behaviour
// - Big-endian: lower axis address returns sample bits 11 to 4.
// - Big-endian: upper address holds bits 3 to 0 high, low nibble zero.
// - Buffer mode off: status register always reads zero.
// - Status: watermark bit 7, overflow bit 6, count bits 5 to 0, reset zero.
// - Watermark set while stored count is at or above the level.
// - Watermark clears once reads take the count below the level.
// - Flush clears the watermark.
// - Mode off disables buffer, drops contents, clears watermark.
// - Burst from status returns status then sample bytes, draining the buffer.
// - Watermark event can drive either interrupt pin when enabled.
// - Count runs 0 to 32; arrival at 32 keeps 32, sets overflow.
// - Overflow clears on a sample read, flush, or disable.
// - Endianness select one gives big-endian; reset default little-endian.
// - Fast read skips upper bytes; upper bits sit at lower address.
`timescale 1ns/1ps
`default_nettype none

module abs_top (
	input wire logic MCLK_I,
	input wire logic ARST_N_I,
	input wire logic SPI_SCLK_I,
	input wire logic SPI_CS_N_I,
	input wire logic SPI_MOSI_I,
	output logic SPI_MISO_O,
	output logic SPI_MISO_OE_O,
	input wire logic SAMPLE_VALID_I,
	input wire logic [11:0] SAMPLE_X_I,
	input wire logic [11:0] SAMPLE_Y_I,
	input wire logic [11:0] SAMPLE_Z_I,
	input wire logic [1:0] BUFFER_MODE_I,
	input wire logic [5:0] WATERMARK_LEVEL_I,
	input wire logic BUFFER_FLUSH_I,
	input wire logic ENDIANNESS_SELECT_I,
	input wire logic FAST_READ_I,
	input wire logic WATERMARK_INT_EN_I,
	input wire logic WATERMARK_INT_ROUTE_I,
	output logic INTERRUPT_PIN_ONE_O,
	output logic INTERRUPT_PIN_TWO_O
);

	// ************************************************************
	// Pin sampling
	// ************************************************************
	wire [2:0] pin_lvl;
	wire [2:0] pin_rise;
	wire [2:0] pin_fall;

	abs_pin_sync u_sync (
		.clk_i(MCLK_I),
		.rst_n_i(ARST_N_I),
		.pin_i({SPI_MOSI_I, SPI_CS_N_I, SPI_SCLK_I}),
		.lvl_o(pin_lvl),
		.rise_o(pin_rise),
		.fall_o(pin_fall)
	);

	wire sclk_rise = pin_rise[0];
	wire sclk_fall = pin_fall[0];
	wire cs_active = ~pin_lvl[1];
	wire mosi = pin_lvl[2];

	// ************************************************************
	// Output data registers
	// ************************************************************
	logic [11:0] out_x;
	logic [11:0] out_y;
	logic [11:0] out_z;

	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			out_x <= abs_pkg::SAMPLE_RESET;
			out_y <= abs_pkg::SAMPLE_RESET;
			out_z <= abs_pkg::SAMPLE_RESET;
		end else if (SAMPLE_VALID_I) begin
			out_x <= SAMPLE_X_I;
			out_y <= SAMPLE_Y_I;
			out_z <= SAMPLE_Z_I;
		end
	end

	// ************************************************************
	// Sample buffer
	// ************************************************************
	wire mode_on = (BUFFER_MODE_I != abs_pkg::MODE_OFF);
	wire [35:0] head;
	wire [5:0] count;
	wire ovf;
	wire wmrk;
	wire pop_req;

	abs_sample_buffer u_buf (
		.clk_i(MCLK_I),
		.rst_n_i(ARST_N_I),
		.mode_on_i(mode_on),
		.flush_i(BUFFER_FLUSH_I),
		.level_i(WATERMARK_LEVEL_I),
		.push_i(SAMPLE_VALID_I),
		.data_i({SAMPLE_Z_I, SAMPLE_Y_I, SAMPLE_X_I}),
		.pop_i(pop_req),
		.head_o(head),
		.count_o(count),
		.ovf_o(ovf),
		.wmrk_o(wmrk)
	);

	wire [11:0] head_x = head[11:0];
	wire [11:0] head_y = head[23:12];
	wire [11:0] head_z = head[35:24];

	// ************************************************************
	// Register read selection
	// ************************************************************
	abs_pkg::abs_phase_t phase;
	logic [7:0] rx;
	logic [7:0] tx;
	logic [6:0] addr;
	logic [2:0] bit_cnt;
	logic byte_done;
	logic read_en;
	logic miso_oe;

	wire be = ENDIANNESS_SELECT_I;
	wire fast = FAST_READ_I;
	wire [6:0] last_addr = fast ? abs_pkg::ADDR_BUF_LAST_FAST : abs_pkg::ADDR_BUF_LAST;

	// Auto-increment; the buffer window wraps so one burst walks all samples
	function automatic logic [6:0] abs_advance(input logic [6:0] a, input logic f, input logic [6:0] last);
		logic in_data;
		in_data = (a >= abs_pkg::ADDR_X_A && a <= abs_pkg::ADDR_Z_B)
			|| (a >= abs_pkg::ADDR_BUF_FIRST && a <= abs_pkg::ADDR_BUF_LAST);
		if (a == last) begin
			abs_advance = abs_pkg::ADDR_BUF_FIRST;
		end else if (f && in_data) begin
			abs_advance = a + abs_pkg::ADDR_STEP_FAST;
		end else begin
			abs_advance = a + abs_pkg::ADDR_STEP;
		end
	endfunction

	wire in_cmd = (phase == abs_pkg::PH_CMD);
	wire [6:0] load_addr = in_cmd ? rx[6:0] : abs_advance(addr, fast, last_addr);
	wire load_read = in_cmd ? rx[abs_pkg::CMD_READ_BIT] : read_en;
	wire load = sclk_fall & cs_active & byte_done & (phase != abs_pkg::PH_IDLE) & load_read;

	// Disabled buffer hides every flag, the count included
	wire [7:0] status_byte = mode_on ? {wmrk, ovf, count} : abs_pkg::STATUS_OFF;

	wire [7:0] rd_byte =
		(load_addr == abs_pkg::ADDR_X_A) ? abs_pkg::abs_lo_byte(out_x, be, fast) :
		(load_addr == abs_pkg::ADDR_X_A + 7'h01) ? abs_pkg::abs_hi_byte(out_x, be) :
		(load_addr == abs_pkg::ADDR_Y_A) ? abs_pkg::abs_lo_byte(out_y, be, fast) :
		(load_addr == abs_pkg::ADDR_Y_B) ? abs_pkg::abs_hi_byte(out_y, be) :
		(load_addr == abs_pkg::ADDR_Z_A) ? abs_pkg::abs_lo_byte(out_z, be, fast) :
		(load_addr == abs_pkg::ADDR_Z_B) ? abs_pkg::abs_hi_byte(out_z, be) :
		(load_addr == abs_pkg::ADDR_STATUS) ? status_byte :
		(load_addr == abs_pkg::ADDR_BUF_FIRST) ? abs_pkg::abs_lo_byte(head_x, be, fast) :
		(load_addr == abs_pkg::ADDR_BUF_FIRST + 7'h01) ? abs_pkg::abs_hi_byte(head_x, be) :
		(load_addr == abs_pkg::ADDR_BUF_FIRST + 7'h02) ? abs_pkg::abs_lo_byte(head_y, be, fast) :
		(load_addr == abs_pkg::ADDR_BUF_FIRST + 7'h03) ? abs_pkg::abs_hi_byte(head_y, be) :
		(load_addr == abs_pkg::ADDR_BUF_LAST_FAST) ? abs_pkg::abs_lo_byte(head_z, be, fast) :
		(load_addr == abs_pkg::ADDR_BUF_LAST) ? abs_pkg::abs_hi_byte(head_z, be) :
		abs_pkg::BYTE_RESET;

	// Pop only after the host has clocked out the last bit of a sample's
	// final byte: a frame cut short, or the closing clock fall that loads
	// the byte after it, must never drop an unread sample. Nothing else is
	// touched by a read
	wire last_shift = sclk_rise & cs_active & read_en & (phase == abs_pkg::PH_DATA)
		& (bit_cnt == abs_pkg::BIT_LAST);
	assign pop_req = last_shift & (addr == last_addr);

	// ************************************************************
	// Serial port
	// ************************************************************
	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			phase <= abs_pkg::PH_IDLE;
			rx <= abs_pkg::BYTE_RESET;
			tx <= abs_pkg::BYTE_RESET;
			addr <= 7'h00;
			bit_cnt <= 3'h0;
			byte_done <= 1'b0;
			read_en <= 1'b0;
			miso_oe <= 1'b0;
		end else if (!cs_active) begin
			phase <= abs_pkg::PH_IDLE;
			miso_oe <= 1'b0;
			byte_done <= 1'b0;
			bit_cnt <= 3'h0;
		end else begin
			case (phase)
				abs_pkg::PH_IDLE: begin
					phase <= abs_pkg::PH_CMD;
					bit_cnt <= 3'h0;
					byte_done <= 1'b0;
				end
				abs_pkg::PH_CMD, abs_pkg::PH_DATA: begin
					if (sclk_rise) begin
						rx <= {rx[6:0], mosi};
						bit_cnt <= bit_cnt + 3'h1;
						byte_done <= (bit_cnt == abs_pkg::BIT_LAST);
					end else if (sclk_fall && byte_done) begin
						byte_done <= 1'b0;
						addr <= load_addr;
						phase <= abs_pkg::PH_DATA;
						if (in_cmd) begin
							read_en <= rx[abs_pkg::CMD_READ_BIT];
							miso_oe <= rx[abs_pkg::CMD_READ_BIT];
						end
						if (load) begin
							tx <= rd_byte;
						end
					end else if (sclk_fall) begin
						tx <= {tx[6:0], 1'b0};
					end
				end
				default: begin
					phase <= abs_pkg::PH_IDLE;
				end
			endcase
		end
	end

	assign SPI_MISO_O = tx[7];
	assign SPI_MISO_OE_O = miso_oe;

	// ************************************************************
	// Interrupt routing
	// ************************************************************
	logic int_one;
	logic int_two;

	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			int_one <= 1'b0;
			int_two <= 1'b0;
		end else begin
			int_one <= WATERMARK_INT_EN_I & ~WATERMARK_INT_ROUTE_I & wmrk;
			int_two <= WATERMARK_INT_EN_I & WATERMARK_INT_ROUTE_I & wmrk;
		end
	end

	assign INTERRUPT_PIN_ONE_O = int_one;
	assign INTERRUPT_PIN_TWO_O = int_two;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!ARST_N_I);

	sequence seq_load_at(logic [6:0] a);
		load && load_addr == a;
	endsequence

	sequence seq_last_load;
		load && !in_cmd && addr == last_addr;
	endsequence

	// Bits leave MSB first; a pop lands between two loads, never on one
	sequence seq_last_shift;
		sclk_rise && cs_active && read_en && phase == abs_pkg::PH_DATA && bit_cnt == abs_pkg::BIT_LAST
			&& addr == last_addr;
	endsequence

	be_upper_lo_a: assert property (seq_load_at(abs_pkg::ADDR_Y_A) and (be && !fast && !SAMPLE_VALID_I)
		|=> tx == out_y[11:4]) else $error("big-endian lower byte wrong");
	be_lower_hi_a: assert property (seq_load_at(abs_pkg::ADDR_Z_B) and (be && !fast && !SAMPLE_VALID_I)
		|=> tx == {out_z[3:0], 4'h0}) else $error("big-endian upper byte wrong");
	le_default_a: assert property (seq_load_at(abs_pkg::ADDR_Y_A) and (!be && !fast && !SAMPLE_VALID_I)
		|=> tx == out_y[7:0]) else $error("little-endian byte wrong");
	status_off_a: assert property (seq_load_at(abs_pkg::ADDR_STATUS) and !mode_on |=> tx == 8'h00)
		else $error("status not zero when off");
	status_fields_a: assert property (seq_load_at(abs_pkg::ADDR_STATUS) and mode_on
		|=> tx == {$past(wmrk), $past(ovf), $past(count)}) else $error("status fields wrong");
	burst_wrap_a: assert property (seq_last_load |-> load_addr == abs_pkg::ADDR_BUF_FIRST && !pop_req)
		else $error("burst did not wrap");
	pop_drain_a: assert property (seq_last_shift and (mode_on && count != 6'h00)
		and (!SAMPLE_VALID_I && !BUFFER_FLUSH_I) |=> count == $past(count) - 6'h01 && !ovf)
		else $error("sample not popped after its last byte");
	shift_out_a: assert property (sclk_fall && cs_active && !byte_done && phase != abs_pkg::PH_IDLE
		|=> tx == {$past(tx[6:0]), 1'b0}) else $error("reply byte not shifted");
	fast_skip_a: assert property (load && !in_cmd && fast && addr == abs_pkg::ADDR_BUF_FIRST
		|-> load_addr == abs_pkg::ADDR_BUF_FIRST + 7'h02) else $error("fast read did not skip");
	int_route_a: assert property (wmrk && WATERMARK_INT_EN_I && !WATERMARK_INT_ROUTE_I
		|=> INTERRUPT_PIN_ONE_O && !INTERRUPT_PIN_TWO_O) else $error("interrupt not routed");
	int_route_two_a: assert property (wmrk && WATERMARK_INT_EN_I && WATERMARK_INT_ROUTE_I
		|=> !INTERRUPT_PIN_ONE_O && INTERRUPT_PIN_TWO_O) else $error("interrupt not routed to pin two");
	read_no_side_a: assert property (load && mode_on && !SAMPLE_VALID_I && !BUFFER_FLUSH_I
		&& $stable(BUFFER_MODE_I) |=> $stable(count)) else $error("read changed count");
	miso_quiet_a: assert property (!cs_active |=> (!SPI_MISO_OE_O)[*2]) else $error("output enabled while deselected");

endmodule

`default_nettype wire

// *** abs_host_model.sv ***
/*
 * Host processor model for the serial register port: mode 0, MSB first,
 * one command byte then any number of data bytes per frame.
 * Assumes it is clocked by the core clock and that the link clock period
 * is 8 core cycles (64 ns), low for 5 cycles and high for 3.
 */
`timescale 1ns/1ps
`default_nettype none

module abs_host_model (
	input wire logic clk_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o,
	input wire logic miso_i,
	input wire logic miso_oe_i
);
	logic [7:0] rx[$];
	int oe_miss = 0;

	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// ************************************************************
	// One frame
	// ************************************************************
	// Long low phase: the reply bit lands 3-4 core cycles after the fall,
	// so sampling at the rise 5 cycles later never races it
	task automatic xfer(input logic [7:0] cmd, input int n);
		logic [7:0] sh;
		logic r;
		rx.delete();
		sh = cmd;
		cs_n_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		for (int i = 0; i < 8 * (n + 1); i++) begin
			sclk_o <= 1'b0;
			mosi_o <= sh[7];
			repeat (5) @(posedge clk_i);
			r = miso_i;
			if (i >= 8 && miso_oe_i !== cmd[7]) oe_miss++;
			sclk_o <= 1'b1;
			sh = {sh[6:0], r};
			if (i % 8 == 7 && i > 7) rx.push_back(sh);
			repeat (3) @(posedge clk_i);
		end
		sclk_o <= 1'b0;
		repeat (5) @(posedge clk_i);
		cs_n_o <= 1'b1;
		// Released data line must not keep showing the last bit
		mosi_o <= ~mosi_o;
		repeat (8) @(posedge clk_i);
	endtask
endmodule

`default_nettype wire

// *** accel_buffer_status_and_layout_tb.sv ***
/*
 * Self-checking bench for the sample buffer read side: a queue model of
 * the buffer and registers is compared with every byte the host reads.
 * Assumes abs_top and abs_host_model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module accel_buffer_status_and_layout_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sclk, cs_n, mosi, miso, miso_oe, pin1, pin2;
	logic valid, flush, be, fast, int_en, route;
	logic [11:0] sx, sy, sz;
	logic [1:0] mode;
	logic [5:0] level;
	logic [31:0] seed = 32'h24d9;
	logic [35:0] q[$];
	logic [35:0] last;
	logic ovf;
	int err_count = 0;
	int comparisons = 0;

	always #4 clk = ~clk;

	abs_top abs_top_i (.MCLK_I(clk), .ARST_N_I(rst_n), .SPI_SCLK_I(sclk), .SPI_CS_N_I(cs_n),
		.SPI_MOSI_I(mosi), .SPI_MISO_O(miso), .SPI_MISO_OE_O(miso_oe), .SAMPLE_VALID_I(valid),
		.SAMPLE_X_I(sx), .SAMPLE_Y_I(sy), .SAMPLE_Z_I(sz), .BUFFER_MODE_I(mode),
		.WATERMARK_LEVEL_I(level), .BUFFER_FLUSH_I(flush), .ENDIANNESS_SELECT_I(be),
		.FAST_READ_I(fast), .WATERMARK_INT_EN_I(int_en), .WATERMARK_INT_ROUTE_I(route),
		.INTERRUPT_PIN_ONE_O(pin1), .INTERRUPT_PIN_TWO_O(pin2));

	abs_host_model abs_host_model_i (.clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
		.miso_i(miso), .miso_oe_i(miso_oe));

	// ************************************************************
	// Model and helpers
	// ************************************************************
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function logic wm();
		return mode != 2'h0 && q.size() >= level;
	endfunction

	function logic [7:0] byte_of(input logic [35:0] t, input logic [6:0] a, input logic [6:0] base);
		logic [11:0] s;
		s = t[35 - 12 * ((a - base) >> 1) -: 12];
		if (a[0] == base[0]) return (be | fast) ? s[11:4] : s[7:0];
		return be ? {s[3:0], 4'h0} : {{4{s[11]}}, s[11:8]};
	endfunction

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task pins();
		repeat (3) @(posedge clk);
		chk({7'h00, pin1}, {7'h00, int_en & ~route & wm()});
		chk({7'h00, pin2}, {7'h00, int_en & route & wm()});
	endtask

	// Walks the burst address order, popping where the device pops
	task rd(input logic [6:0] a, input int n);
		logic [7:0] e;
		abs_host_model_i.xfer({1'b1, a}, n);
		for (int i = 0; i < n; i++) begin
			e = 8'h00;
			if (a == 7'h0b && mode != 2'h0) e = {wm(), ovf, 6'(q.size())};
			else if (a >= 7'h04 && a <= 7'h09) e = byte_of(last, a, 7'h04);
			else if (a >= 7'h0c && a <= 7'h11) e = byte_of(q[0], a, 7'h0c);
			chk(abs_host_model_i.rx[i], e);
			if (a == 7'h11 || (fast && a == 7'h10)) begin
				void'(q.pop_front());
				ovf = 1'b0;
				a = 7'h0c;
			end
			else if (fast && ((a >= 7'h04 && a <= 7'h09) || a >= 7'h0c)) a = a + 7'h02;
			else a = a + 7'h01;
		end
		pins();
	endtask

	task push(input int n);
		logic [35:0] t;
		repeat (n) begin
			t = {rnd(), 4'h0} ^ 36'(rnd());
			@(posedge clk);
			{sx, sy, sz} <= t;
			valid <= 1'b1;
			last = t;
			if (mode != 2'h0 && q.size() < 32) q.push_back(t);
			else if (mode != 2'h0) ovf = 1'b1;
			@(posedge clk);
			valid <= 1'b0;
		end
		pins();
	endtask

	task do_flush();
		@(posedge clk);
		flush <= 1'b1;
		@(posedge clk);
		flush <= 1'b0;
		q.delete();
		ovf = 1'b0;
	endtask

	task results();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end
		else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		$display("mismatch at %0t: run did not finish", $time);
		results();
	end

	initial begin
		{valid, flush, be, fast, int_en, route, ovf} = '0;
		{sx, sy, sz} = '0;
		mode = 2'h1;
		level = 6'h05;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		rd(7'h0b, 1);
		mode <= 2'h0;
		push(3);
		be <= 1'b1;
		rd(7'h04, 8);
		mode <= 2'h1;
		be <= 1'b0;
		int_en <= 1'b1;
		push(4);
		rd(7'h06, 6);
		push(1);
		route <= 1'b1;
		push(28);
		rd(7'h0b, 1);
		abs_host_model_i.xfer(8'h0b, 1);
		rd(7'h0c, 6);
		fast <= 1'b1;
		rd(7'h0b, 1 + 3 * 27);
		fast <= 1'b0;
		be <= 1'b1;
		rd(7'h0b, 1 + 6 * 4);
		rd(7'h0b, 1);
		push(33);
		do_flush();
		rd(7'h0b, 1);
		push(33);
		mode <= 2'h0;
		q.delete();
		ovf = 1'b0;
		rd(7'h0b, 1);
		mode <= 2'h2;
		rd(7'h0b, 1);
		chk(8'(abs_host_model_i.oe_miss), 8'h00);
		results();
	end
endmodule

`default_nettype wire
